//--- pkg/arj_cfg.svh
// register offsets, field positions, reset values and widths of the result justify block
`ifndef ARJ_CFG_SVH
`define ARJ_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define ARJ_OFF_CTRL         4'h0
`define ARJ_OFF_RESULT_HIGH  4'h4
`define ARJ_OFF_RESULT_LOW   4'h8
`define ARJ_OFF_STATUS       4'hC

// ****************************************
// field positions
// ****************************************
`define ARJ_CTRL_JUSTIFY_BIT 0
`define ARJ_STAT_DONE_BIT    0
`define ARJ_STAT_OVR_BIT     1
`define ARJ_STAT_CNT_LSB     16
`define ARJ_STAT_CNT_MSB     31

// ****************************************
// widths and reset values
// ****************************************
`define ARJ_RESULT_W         10
`define ARJ_CNT_W            16
`define ARJ_RST_JUSTIFY      1'b0
`define ARJ_RST_FLAG         1'b0
`define ARJ_RST_CNT          16'h0000
`define ARJ_RST_WORD         32'h0000_0000

`endif

//--- pkg/arj_pkg.sv
// types shared by the result justify block
package arj_pkg;

  // justification choice held in the control register
  typedef enum logic {
    ARJ_LEFT  = 1'b0,
    ARJ_RIGHT = 1'b1
  } arj_justify_t;

  // complete state of the register bank
  typedef struct packed {
    logic         justify;
    logic         done;
    logic         overrun;
    logic [7:0]   res_hi;
    logic [7:0]   res_lo;
    logic [15:0]  conv_cnt;
    logic         ack;
    logic [31:0]  rdata;
  } arj_state_t;

endpackage

//--- verification/arj_regs_test.sv
// self-checking bench for the result justify register bank
`timescale 1ns/1ps
`default_nettype none
`include "arj_cfg.svh"

module arj_regs_test;
  import arj_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, conv_done_i;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        ack_o, jsel;
  logic [9:0]  conversion_result_i, r;
  logic [7:0]  hi_o, lo_o, eh, el;
  integer      errors, samples_checked;
  logic [3:0]  sel_v;
  // acquisition wait before each conversion, in clock cycles
  localparam int ACQ_CYCLES = 4;
  logic [9:0]  vec [4] = '{10'h2D5, 10'h3FF, 10'h000, 10'h12A};

  arj_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .conv_done_i(conv_done_i), .conversion_result_i(conversion_result_i),
    .result_justify_select_o(jsel), .result_high_byte_o(hi_o), .result_low_byte_o(lo_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one classic cycle; the answer is taken at the edge where ack is seen high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= sel_v;
    @(negedge clk_i);
    while (ack_o !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  task automatic conv(input logic [9:0] v);
    repeat (ACQ_CYCLES) @(posedge clk_i);
    @(posedge clk_i);
    conv_done_i <= 1'b1; conversion_result_i <= v;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    @(negedge clk_i);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog: the tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    errors = 0; samples_checked = 0;
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 4'h0; sel_i = 4'h0;
    dat_i = 32'h0000_0000; conv_done_i = 1'b0; conversion_result_i = 10'h000;
    sel_v = 4'hF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `ARJ_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    for (int j = 0; j < 2; j++) begin
      wb(1'b1, `ARJ_OFF_CTRL, j);
      for (int i = 0; i < 4; i++) begin
        r = vec[i];
        conv(r);
        eh = j ? {6'h00, r[9:8]} : r[9:2];
        el = j ? r[7:0] : {r[1:0], 6'h00};
        chk(jsel, j);
        chk(hi_o, eh);
        chk(lo_o, el);
        wb(1'b0, `ARJ_OFF_RESULT_HIGH, 32'h0000_0000);
        chk(q, {24'h00_0000, eh});
        if (j == 1) chk(q[1:0], r[9:8]);
        wb(1'b0, `ARJ_OFF_RESULT_LOW, 32'h0000_0000);
        chk(q, {24'h00_0000, el});
        if (j == 0) chk(q[7:6], r[1:0]);
      end
    end
    // eight completions without a clear: count 8, done and overrun set
    wb(1'b0, `ARJ_OFF_STATUS, 32'h0000_0000);
    chk(q, 32'h0008_0003);
    wb(1'b1, `ARJ_OFF_STATUS, 32'h0000_0003);
    wb(1'b0, `ARJ_OFF_STATUS, 32'h0000_0000);
    chk(q, 32'h0008_0000);
    // a mode change alone must not touch the stored bytes
    wb(1'b1, `ARJ_OFF_CTRL, 32'h0000_0000);
    chk(hi_o, 8'h01);
    chk(lo_o, 8'h2A);
    wb(1'b1, `ARJ_OFF_RESULT_HIGH, 32'h0000_00A5);
    wb(1'b0, `ARJ_OFF_RESULT_HIGH, 32'h0000_0000);
    chk(q, 32'h0000_00A5);
    // writes with lane zero off are acked but ignored
    sel_v = 4'hE;
    wb(1'b1, `ARJ_OFF_CTRL, 32'h0000_0001);
    wb(1'b1, `ARJ_OFF_RESULT_HIGH, 32'h0000_005A);
    sel_v = 4'hF;
    @(negedge clk_i);
    chk(jsel, 1'b0);
    wb(1'b0, `ARJ_OFF_RESULT_HIGH, 32'h0000_0000);
    chk(q, 32'h0000_00A5);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // right justification selected so the reset visibly clears it
    wb(1'b1, `ARJ_OFF_CTRL, 32'h0000_0001);
    @(negedge clk_i);
    chk(jsel, 1'b1);
    // a mid-run reset keeps the result bytes
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk(hi_o, 8'hA5);
    chk(lo_o, 8'h2A);
    chk(jsel, 1'b0);
    wb(1'b0, `ARJ_OFF_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // after reset the next completion packs left justified
    conv(vec[0]);
    chk(hi_o, 8'hB5);
    chk(lo_o, 8'h40);
    give_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/arj_pack.sv
// packs a 10-bit conversion result into the high and low result bytes
`timescale 1ns/1ps
`default_nettype none

module arj_pack
  import arj_pkg::*;
(
  // conversion input
  input  wire logic [9:0] result_i,
  input  wire logic       justify_i,
  // packed bytes
  output logic      [7:0] high_o,
  output logic      [7:0] low_o
);

  // ****************************************
  // byte placement
  // ****************************************
  always_comb begin
    if (justify_i == ARJ_RIGHT) begin
      high_o = {6'h00, result_i[9:8]};
      low_o  = result_i[7:0];
    end else begin
      high_o = result_i[9:2];
      low_o  = {result_i[1:0], 6'h00};
    end
  end

endmodule

`default_nettype wire

//--- verilog/arj_regs.sv
// result byte registers of a 10-bit converter with left or right justification
//
// Behaviour
// - left: high byte holds result nine..two
// - left: low byte top two bits hold one..zero
// - right: high byte low bits hold nine..eight
// - right: low byte holds result seven..zero
`timescale 1ns/1ps
`default_nettype none
`include "arj_cfg.svh"

module arj_regs
  import arj_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // converter core
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conversion_result_i,
  output logic             result_justify_select_o,
  // result bytes as seen by the core side
  output logic      [7:0]  result_high_byte_o,
  output logic      [7:0]  result_low_byte_o
);

  // ****************************************
  // state
  // ****************************************
  arj_state_t state_ff;
  arj_state_t nxt_state;

  logic [7:0] packed_hi;
  logic [7:0] packed_lo;
  logic       bus_req;
  logic       bus_wr;
  logic       wr_lane0;
  logic [31:0] rd_word;

  // ****************************************
  // result packing
  // ****************************************
  arj_pack u_pack (
    .result_i  (conversion_result_i),
    .justify_i (state_ff.justify),
    .high_o    (packed_hi),
    .low_o     (packed_lo)
  );

  // ****************************************
  // bus decode
  // ****************************************
  // a write commits on the edge where the master samples ack
  assign bus_req  = cyc_i & stb_i;
  assign bus_wr   = bus_req & we_i & state_ff.ack;
  assign wr_lane0 = bus_wr & sel_i[0];

  // unmapped offsets read as zero and are acked like any other
  always_comb begin
    rd_word = `ARJ_RST_WORD;
    case (adr_i)
      `ARJ_OFF_CTRL: begin
        rd_word[`ARJ_CTRL_JUSTIFY_BIT] = state_ff.justify;
      end
      `ARJ_OFF_RESULT_HIGH: begin
        rd_word[7:0] = state_ff.res_hi;
      end
      `ARJ_OFF_RESULT_LOW: begin
        rd_word[7:0] = state_ff.res_lo;
      end
      `ARJ_OFF_STATUS: begin
        rd_word[`ARJ_STAT_DONE_BIT] = state_ff.done;
        rd_word[`ARJ_STAT_OVR_BIT]  = state_ff.overrun;
        rd_word[`ARJ_STAT_CNT_MSB:`ARJ_STAT_CNT_LSB] = state_ff.conv_cnt;
      end
      default: begin
        rd_word = `ARJ_RST_WORD;
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_state = state_ff;

    // one-cycle ack, dropped in the cycle after it was given
    nxt_state.ack = bus_req & ~state_ff.ack;
    if (bus_req & ~state_ff.ack) begin
      nxt_state.rdata = rd_word;
    end

    // software writes, low byte lane only
    if (wr_lane0) begin
      case (adr_i)
        `ARJ_OFF_CTRL: begin
          nxt_state.justify = dat_i[`ARJ_CTRL_JUSTIFY_BIT];
        end
        `ARJ_OFF_RESULT_HIGH: begin
          nxt_state.res_hi = dat_i[7:0];
        end
        `ARJ_OFF_RESULT_LOW: begin
          nxt_state.res_lo = dat_i[7:0];
        end
        `ARJ_OFF_STATUS: begin
          // write one to clear
          if (dat_i[`ARJ_STAT_DONE_BIT]) begin
            nxt_state.done = `ARJ_RST_FLAG;
          end
          if (dat_i[`ARJ_STAT_OVR_BIT]) begin
            nxt_state.overrun = `ARJ_RST_FLAG;
          end
        end
        default: begin
          nxt_state.justify = state_ff.justify;
        end
      endcase
    end

    // a completing conversion wins over a software write in the same cycle
    // completion writes results
    if (conv_done_i) begin
      nxt_state.res_hi   = packed_hi;
      nxt_state.res_lo   = packed_lo;
      nxt_state.done     = 1'b1;
      nxt_state.conv_cnt = state_ff.conv_cnt + 16'h0001;
      if (state_ff.done) begin
        nxt_state.overrun = 1'b1;
      end
    end

    // results survive reset
    // only control, status and bus state is reset; the result bytes keep whatever they held
    if (rst_i) begin
      nxt_state.justify  = `ARJ_RST_JUSTIFY;
      nxt_state.done     = `ARJ_RST_FLAG;
      nxt_state.overrun  = `ARJ_RST_FLAG;
      nxt_state.conv_cnt = `ARJ_RST_CNT;
      nxt_state.ack      = 1'b0;
      nxt_state.rdata    = `ARJ_RST_WORD;
    end
  end

  // no power-on value: result bytes start unknown as the real cells do
  always_ff @(posedge clk_i) begin
    state_ff <= nxt_state;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dat_o                   = state_ff.rdata;
  assign ack_o                   = state_ff.ack;
  assign result_justify_select_o = state_ff.justify;
  assign result_high_byte_o      = state_ff.res_hi;
  assign result_low_byte_o       = state_ff.res_lo;

  // ****************************************
  // assertions
  // ****************************************
  property p_left_high;
    @(posedge clk_i) disable iff (rst_i)
      (conv_done_i && !state_ff.justify)
      |=> (result_high_byte_o == $past(conversion_result_i[9:2]));
  endproperty
  a_left_high: assert property (p_left_high)
    else $error("left high byte does not hold result bits nine to two");

  property p_left_low;
    @(posedge clk_i) disable iff (rst_i)
      (conv_done_i && !state_ff.justify)
      |=> (result_low_byte_o[7:6] == $past(conversion_result_i[1:0]))
          && (result_low_byte_o[5:0] == 6'h00);
  endproperty
  a_left_low: assert property (p_left_low)
    else $error("left low byte top bits wrong");

  property p_right_high;
    @(posedge clk_i) disable iff (rst_i)
      (conv_done_i && state_ff.justify)
      |=> ({result_high_byte_o[7:2], result_high_byte_o[1:0]}
           == {6'h00, $past(conversion_result_i[9:8])});
  endproperty
  a_right_high: assert property (p_right_high)
    else $error("right high byte does not hold result bits nine and eight");

  property p_right_low;
    @(posedge clk_i) disable iff (rst_i)
      (conv_done_i && state_ff.justify)
      |=> (result_low_byte_o == $past(conversion_result_i[7:0]));
  endproperty
  a_right_low: assert property (p_right_low)
    else $error("right low byte does not hold result bits seven to zero");

  logic res_wr_hit;
  assign res_wr_hit = wr_lane0
                      && ((adr_i == `ARJ_OFF_RESULT_HIGH) || (adr_i == `ARJ_OFF_RESULT_LOW));

  // armed once a conversion has landed since reset; before that the bytes may be unknown
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state_ff.conv_cnt != `ARJ_RST_CNT) && !conv_done_i && !res_wr_hit
      |=> $stable(result_high_byte_o) && $stable(result_low_byte_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("result bytes changed without completion or write");

  property p_done_count;
    @(posedge clk_i) disable iff (rst_i)
      conv_done_i
      |=> state_ff.done && (state_ff.conv_cnt == $past(state_ff.conv_cnt) + 16'h0001);
  endproperty
  a_done_count: assert property (p_done_count)
    else $error("completion did not set done or advance the count");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack is not a single cycle answer one cycle after request");

  // reset clears every control bit and both bus outputs
  property p_reset_clear;
    @(posedge clk_i)
      rst_i
      |=> !ack_o && (dat_o == `ARJ_RST_WORD)
          && (result_justify_select_o == `ARJ_RST_JUSTIFY)
          && (state_ff.done == `ARJ_RST_FLAG) && (state_ff.overrun == `ARJ_RST_FLAG)
          && (state_ff.conv_cnt == `ARJ_RST_CNT);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left control state or bus outputs set");

  // ack only ever answers a request
  property p_ack_needs_req;
    @(posedge clk_i) disable iff (rst_i)
      !bus_req |=> !ack_o;
  endproperty
  a_ack_needs_req: assert property (p_ack_needs_req)
    else $error("ack raised without a request");

  // read data only moves when a request is taken, read or write alike
  property p_rdata_hold;
    @(posedge clk_i) disable iff (rst_i)
      !(bus_req && !ack_o) |=> $stable(dat_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a taken request");

  // a taken read of the high byte returns it in the low lane
  property p_read_high;
    @(posedge clk_i) disable iff (rst_i)
      (bus_req && !ack_o && (adr_i == `ARJ_OFF_RESULT_HIGH))
      |=> (dat_o == {24'h00_0000, $past(result_high_byte_o)});
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("high byte read returned the wrong word");

  // a committed control write lands in the justify bit
  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && (adr_i == `ARJ_OFF_CTRL))
      |=> (result_justify_select_o == $past(dat_i[`ARJ_CTRL_JUSTIFY_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not set the justify bit");

  // lane zero off: the write is acked but must not reach the control bit
  property p_lane_off;
    @(posedge clk_i) disable iff (rst_i)
      (bus_wr && !sel_i[0])
      |=> $stable(result_justify_select_o);
  endproperty
  a_lane_off: assert property (p_lane_off)
    else $error("write without lane zero changed the justify bit");

  // writing one to done clears it unless a completion lands too
  property p_done_clear;
    @(posedge clk_i) disable iff (rst_i)
      (wr_lane0 && (adr_i == `ARJ_OFF_STATUS) && dat_i[`ARJ_STAT_DONE_BIT] && !conv_done_i)
      |=> !state_ff.done;
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("done survived a write one to clear");

  // a completion while done is still set flags an overrun
  property p_overrun_set;
    @(posedge clk_i) disable iff (rst_i)
      (conv_done_i && state_ff.done) |=> state_ff.overrun;
  endproperty
  a_overrun_set: assert property (p_overrun_set)
    else $error("completion over an unread result did not flag overrun");

endmodule

`default_nettype wire
